// ===== caller_id_fsk_generator.sv
// caller id fsk framer and modulator shared by four line channels
//
// Overview of operation
// - v.23: ones 1300 hz, zeros 2100 hz
// - bell 202: 1200/2200 hz, 1200 baud
// - seizure pairs, then mark ones, then bytes
// - flag run of ones after each byte, the last included
// - four length registers frame each transmission
// - 64-byte message buffer, host read and write
// - channel select routes output to one line
// - one bit picks the modulation standard
// - select 0 bell 202, 1 v.23
// - go bit runs whole sequence unattended
// - byte framed: start zero, data, stop one
// - loop bytes; clear go when all sent
// - after send: hold ones, else mute
// - hold re-armed only by a new start
// - host bytes kept as written, line lsb first
// - seizure pairs are twice programmed length
// - flag length 0 to 255 bits
// - message count valid 0 to 64 only
`default_nettype none

module caller_id_fsk_generator
    import fsk_gen_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic reg_wr,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // message buffer port
    input wire logic buf_wr,
    input wire logic [BUF_AW-1:0] buf_addr,
    input wire logic [7:0] buf_wdata,
    output logic [7:0] buf_rdata,
    // sample stream to the selected line
    output logic out_valid,
    input wire logic out_ready,
    output logic signed [15:0] out_sample,
    output logic [1:0] out_channel
);

    typedef struct packed {
        logic [7:0] flag_length;
        logic [7:0] message_count;
        logic [7:0] seizure_length;
        logic [7:0] mark_length;
        logic modulator_enable;
        logic [1:0] line_channel_select;
        logic modulation_standard_select;
        logic transmit_go;
        logic hold_ones_after_send;
        logic armed;
        stage_t stage;
        logic [9:0] bit_cnt;
        logic [6:0] byte_idx;
        logic [7:0] shreg;
        logic [13:0] tick;
        logic pending;
        logic [12:0] baud_acc;
        logic [15:0] phase;
        logic [1:0] fill;
        logic [15:0] smp0;
        logic [15:0] smp1;
        logic [1:0] ch0;
        logic [1:0] ch1;
        logic [7:0] rdata;
    } state_t;

    state_t st;
    state_t next_st;
    logic [7:0] message_buffer [BUF_DEPTH];
    logic cur_bit;
    logic [15:0] inc;
    logic [13:0] mag;
    logic [15:0] sample;
    logic push;
    logic pop;
    logic bit_done;
    logic start;

    // the buffer is host-visible as stored; the shifter below puts bit 0 out first
    always_ff @(posedge clk) begin
        if (buf_wr) begin
            message_buffer[buf_addr] <= buf_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_rdata <= 8'h00;
        end else begin
            buf_rdata <= message_buffer[buf_addr];
        end
    end

    // counts above the buffer size are clipped rather than wrapping into old bytes
    function automatic stage_t bytes_or_end(state_t s, logic [6:0] idx);
        logic [7:0] cnt;
        cnt = (s.message_count > MSG_COUNT_MAX) ? MSG_COUNT_MAX : s.message_count;
        if ({1'b0, idx} < cnt) begin
            return S_START;
        end else if (s.armed && s.hold_ones_after_send) begin
            return S_AFTER;
        end
        return S_IDLE;
    endfunction

    function automatic stage_t after_seizure(state_t s);
        if (s.mark_length != 8'h00) begin
            return S_MARK;
        end
        return bytes_or_end(s, s.byte_idx);
    endfunction

    function automatic state_t enter(state_t s, stage_t g);
        s.stage = g;
        unique case (g)
            S_SEIZE: s.bit_cnt = ({2'b00, s.seizure_length} << SEIZE_SHIFT) - 10'h001;
            S_MARK: s.bit_cnt = {2'b00, s.mark_length} - 10'h001;
            S_FLAG: s.bit_cnt = {2'b00, s.flag_length} - 10'h001;
            S_DATA: s.bit_cnt = DATA_LAST;
            S_START: s.shreg = message_buffer[s.byte_idx[BUF_AW-1:0]];
            S_IDLE, S_AFTER: s.transmit_go = 1'b0;
            S_STOP: s.bit_cnt = 10'h000;
        endcase
        return s;
    endfunction

    // bit now on the line
    always_comb begin
        unique case (st.stage)
            S_SEIZE: cur_bit = ~st.bit_cnt[0];
            S_START: cur_bit = 1'b0;
            S_DATA: cur_bit = st.shreg[0];
            default: cur_bit = 1'b1;
        endcase
        if (st.modulation_standard_select) begin
            inc = cur_bit ? INC_V23_MARK : INC_V23_SPACE;
        end else begin
            inc = cur_bit ? INC_BELL_MARK : INC_BELL_SPACE;
        end
        // triangle shape keeps the tone cheap; filtering downstream rounds it off
        mag = st.phase[14] ? ~st.phase[13:0] : st.phase[13:0];
        if (st.stage == S_IDLE) begin
            sample = 16'h0000;
        end else if (st.phase[15]) begin
            sample = 16'h0000 - {2'b00, mag};
        end else begin
            sample = {2'b00, mag};
        end
    end

    always_comb begin
        next_st = st;
        start = 1'b0;
        bit_done = 1'b0;
        pop = out_ready && (st.fill != 2'h0);
        push = st.pending && ((st.fill != FIFO_FULL) || pop);

        // sample pacing; a stalled receiver holds the pending sample and the whole framer
        if (push) begin
            next_st.pending = 1'b0;
            next_st.phase = st.phase + inc;
            if (st.stage != S_IDLE) begin
                // compare before adding: the 13-bit sum would wrap past 8191
                if (st.baud_acc >= BAUD_WRAP - BAUD_STEP) begin
                    next_st.baud_acc = st.baud_acc - (BAUD_WRAP - BAUD_STEP);
                    bit_done = 1'b1;
                end else begin
                    next_st.baud_acc = st.baud_acc + BAUD_STEP;
                end
            end
        end
        if (st.tick == 14'(SAMPLE_CYCLES - 1)) begin
            next_st.tick = 14'h0000;
            next_st.pending = 1'b1;
        end else begin
            next_st.tick = st.tick + 14'h0001;
        end

        // two-entry output buffer
        if (pop) begin
            next_st.smp0 = st.smp1;
            next_st.ch0 = st.ch1;
            next_st.fill = st.fill - 2'h1;
        end
        if (push) begin
            if (next_st.fill == 2'h0) begin
                next_st.smp0 = sample;
                next_st.ch0 = st.line_channel_select;
            end else begin
                next_st.smp1 = sample;
                next_st.ch1 = st.line_channel_select;
            end
            next_st.fill = next_st.fill + 2'h1;
        end

        // framing sequence, one step per finished bit
        if (bit_done) begin
            unique case (st.stage)
                S_SEIZE: begin
                    if (st.bit_cnt == 10'h000) begin
                        next_st = enter(next_st, after_seizure(st));
                    end else begin
                        next_st.bit_cnt = st.bit_cnt - 10'h001;
                    end
                end
                S_MARK, S_FLAG: begin
                    if (st.bit_cnt == 10'h000) begin
                        next_st = enter(next_st, bytes_or_end(st, st.byte_idx));
                    end else begin
                        next_st.bit_cnt = st.bit_cnt - 10'h001;
                    end
                end
                S_START: next_st = enter(next_st, S_DATA);
                S_DATA: begin
                    next_st.shreg = {1'b0, st.shreg[7:1]};
                    if (st.bit_cnt == 10'h000) begin
                        next_st = enter(next_st, S_STOP);
                    end else begin
                        next_st.bit_cnt = st.bit_cnt - 10'h001;
                    end
                end
                S_STOP: begin
                    next_st.byte_idx = st.byte_idx + 7'h01;
                    if (st.flag_length != 8'h00) begin
                        next_st = enter(next_st, S_FLAG);
                    end else begin
                        next_st = enter(next_st, bytes_or_end(st, st.byte_idx + 7'h01));
                    end
                end
                S_IDLE, S_AFTER: ;
            endcase
        end

        // register writes; a start written with the end-of-message clear wins
        if (reg_wr) begin
            case (reg_addr)
                REG_FLAG_LEN: next_st.flag_length = reg_wdata;
                REG_MSG_COUNT: next_st.message_count = reg_wdata;
                REG_SEIZE_LEN: next_st.seizure_length = reg_wdata;
                REG_MARK_LEN: next_st.mark_length = reg_wdata;
                REG_CONTROL: begin
                    next_st.modulator_enable = reg_wdata[CTL_ENABLE];
                    next_st.line_channel_select = reg_wdata[CTL_CHAN_LO +: 2];
                    next_st.modulation_standard_select = reg_wdata[CTL_STD];
                    next_st.hold_ones_after_send = reg_wdata[CTL_HOLD];
                    if (reg_wdata[CTL_GO] && reg_wdata[CTL_ENABLE]) begin
                        start = 1'b1;
                    end else if (!reg_wdata[CTL_GO]) begin
                        next_st = enter(next_st, S_IDLE);
                    end
                end
                default: ;
            endcase
        end
        if (start) begin
            next_st.transmit_go = 1'b1;
            next_st.armed = 1'b1;
            next_st.byte_idx = 7'h00;
            next_st.baud_acc = 13'h0000;
            if (next_st.seizure_length != 8'h00) begin
                next_st = enter(next_st, S_SEIZE);
            end else begin
                next_st = enter(next_st, after_seizure(next_st));
            end
        end
        // a hold dropped once stays dropped until the next start
        if (!next_st.hold_ones_after_send) begin
            next_st.armed = 1'b0;
        end
        if (next_st.stage == S_AFTER && !next_st.armed) begin
            next_st.stage = S_IDLE;
        end
        if (!next_st.modulator_enable) begin
            next_st = enter(next_st, S_IDLE);
        end

        // register read-back
        unique case (reg_addr)
            REG_FLAG_LEN: next_st.rdata = st.flag_length;
            REG_MSG_COUNT: next_st.rdata = st.message_count;
            REG_SEIZE_LEN: next_st.rdata = st.seizure_length;
            REG_MARK_LEN: next_st.rdata = st.mark_length;
            REG_CONTROL: next_st.rdata = {2'b00, st.hold_ones_after_send, st.transmit_go,
                                          st.modulation_standard_select, st.line_channel_select,
                                          st.modulator_enable};
            default: next_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{stage: S_IDLE, flag_length: REG_RESET, message_count: REG_RESET,
                    seizure_length: REG_RESET, mark_length: REG_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign out_valid = st.fill != 2'h0;
    assign out_sample = st.smp0;
    assign out_channel = st.ch0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_idle_muted: assert property (push && st.stage == S_IDLE
                                   |=> (st.fill == 2'h1 ? st.smp0 : st.smp1) == 16'h0000)
        else $error("idle generator pushed a nonzero sample");
    a_start_zero: assert property (st.stage == S_START |-> !cur_bit)
        else $error("start bit not zero");
    a_stop_one: assert property (st.stage inside {S_STOP, S_FLAG, S_MARK, S_AFTER} |-> cur_bit)
        else $error("mark, stop or flag bit not one");
    a_seize_alternates: assert property (bit_done && st.stage == S_SEIZE && st.bit_cnt != 10'h000
                                         |=> cur_bit != $past(cur_bit))
        else $error("seizure bits do not alternate");
    a_go_cleared: assert property (!start && st.stage != S_IDLE && st.stage != S_AFTER
                                   && next_st.stage inside {S_IDLE, S_AFTER} |=> !st.transmit_go)
        else $error("go bit left set after message");
    a_phase_step: assert property (push |=> st.phase == $past(st.phase) + $past(inc))
        else $error("phase not advanced by tone increment");
    a_tone_pick: assert property (st.modulation_standard_select && cur_bit |-> inc == INC_V23_MARK)
        else $error("v.23 mark increment wrong");
    a_hold_rearm: assert property (!st.armed && !start |=> !st.armed)
        else $error("hold re-armed without a start");
    a_data_lsb: assert property (bit_done && st.stage == S_DATA && st.bit_cnt != 10'h000
                                 |=> cur_bit == $past(st.shreg[1]))
        else $error("data bits not sent lsb first");
    a_fifo_full: assert property (st.fill == FIFO_FULL && !out_ready |-> !push)
        else $error("push into a full buffer");

    c_start: cover property (start);
    c_after: cover property (st.stage == S_STOP ##[1:1000] st.stage == S_AFTER);
    c_full: cover property (st.fill == FIFO_FULL);
    c_byte_done: cover property (st.stage == S_STOP && bit_done);

endmodule

`default_nettype wire

// ===== fsk_gen_pkg.sv
// constants shared by the caller id fsk generator
`default_nettype none

package fsk_gen_pkg;

    // clock and stream timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_HZ = 8000;
    localparam int BAUD = 1200;
    localparam int SAMPLE_CYCLES_DEF = CLK_HZ / SAMPLE_HZ;

    // tone frequencies in hz
    localparam int BELL_MARK_HZ = 1200;
    localparam int BELL_SPACE_HZ = 2200;
    localparam int V23_MARK_HZ = 1300;
    localparam int V23_SPACE_HZ = 2100;

    // phase accumulator and per-sample increments
    localparam int PHASE_W = 16;
    localparam int PHASE_SPAN = 65536;
    localparam logic [15:0] INC_BELL_MARK = 16'(BELL_MARK_HZ * PHASE_SPAN / SAMPLE_HZ);
    localparam logic [15:0] INC_BELL_SPACE = 16'(BELL_SPACE_HZ * PHASE_SPAN / SAMPLE_HZ);
    localparam logic [15:0] INC_V23_MARK = 16'(V23_MARK_HZ * PHASE_SPAN / SAMPLE_HZ);
    localparam logic [15:0] INC_V23_SPACE = 16'(V23_SPACE_HZ * PHASE_SPAN / SAMPLE_HZ);
    localparam logic [12:0] BAUD_STEP = 13'(BAUD);
    localparam logic [12:0] BAUD_WRAP = 13'(SAMPLE_HZ);

    // register indices
    localparam logic [4:0] REG_FLAG_LEN = 5'h13;
    localparam logic [4:0] REG_MSG_COUNT = 5'h14;
    localparam logic [4:0] REG_SEIZE_LEN = 5'h15;
    localparam logic [4:0] REG_MARK_LEN = 5'h16;
    localparam logic [4:0] REG_CONTROL = 5'h17;

    // control register fields
    localparam int CTL_ENABLE = 0;
    localparam int CTL_CHAN_LO = 1;
    localparam int CTL_STD = 3;
    localparam int CTL_GO = 4;
    localparam int CTL_HOLD = 5;
    localparam logic [7:0] REG_RESET = 8'h00;

    // message buffer and framing
    localparam int BUF_DEPTH = 64;
    localparam int BUF_AW = 6;
    localparam logic [7:0] MSG_COUNT_MAX = 8'h40;
    localparam int SEIZE_SHIFT = 2;
    localparam logic [9:0] DATA_LAST = 10'h007;
    localparam logic [1:0] FIFO_FULL = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE, S_SEIZE, S_MARK, S_START, S_DATA, S_STOP, S_FLAG, S_AFTER
    } stage_t;

endpackage

`default_nettype wire

// ===== line_sink.sv
// line side receiver model with prompt and slow acceptance
`default_nettype none
module line_sink
    import fsk_gen_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // stream from the generator
    input wire logic out_valid,
    output logic out_ready,
    input wire logic signed [15:0] out_sample,
    input wire logic [1:0] out_channel,
    // bench control and tallies
    input wire logic slow,
    input wire logic clr,
    output int n_acc,
    output int n_nz,
    output int n_cross,
    output logic [31:0] sum,
    output logic [1:0] last_ch
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap;
    logic prev_neg;
    // one word in 64 cycles is slower than the bench pace of one sample per 20 cycles, so the buffer fills
    assign out_ready = !slow || (gap == 63);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap <= 0;
            n_acc <= 0;
            n_nz <= 0;
            n_cross <= 0;
            sum <= 32'h0;
            last_ch <= 2'h0;
            prev_neg <= 1'b0;
        end else begin
            gap <= (gap + 1) % 64;
            if (clr) begin
                n_acc <= 0;
                n_nz <= 0;
                n_cross <= 0;
                sum <= 32'h0;
            end else if (out_valid && out_ready) begin
                n_acc <= n_acc + 1;
                last_ch <= out_channel;
                if (out_sample !== 16'sh0) begin
                    // order sensitive, so a lost or swapped word shows; zeros skipped so tail length is moot
                    sum <= {sum[30:0], sum[31]} ^ {16'h0, out_sample};
                    n_nz <= n_nz + 1;
                    prev_neg <= out_sample[15];
                    if (out_sample[15] != prev_neg) n_cross <= n_cross + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb_caller_id_fsk_generator.sv
// self-checking bench for the caller id fsk generator
`default_nettype none
module tb_caller_id_fsk_generator
    import fsk_gen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, buf_wr = 1'b0, slow = 1'b0, clr = 1'b0;
    logic [4:0] reg_addr = 5'h0;
    logic [7:0] reg_wdata = 8'h0, buf_wdata = 8'h0, reg_rdata, buf_rdata;
    logic [BUF_AW-1:0] buf_addr = '0;
    logic out_valid, out_ready;
    logic signed [15:0] out_sample;
    logic [1:0] out_channel, last_ch;
    logic [31:0] sum, cs_a, cs_b;
    int n_acc, n_nz, n_cross, nz_a, nz_b, error_cnt = 0, cmp_count = 0;

    always #5 clk = ~clk;

    caller_id_fsk_generator #(.SAMPLE_CYCLES(20)) caller_id_fsk_generator_inst (
        .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .buf_wr(buf_wr), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
        .buf_rdata(buf_rdata), .out_valid(out_valid), .out_ready(out_ready),
        .out_sample(out_sample), .out_channel(out_channel));

    line_sink line_sink_inst (
        .clk(clk), .nrst(nrst), .out_valid(out_valid), .out_ready(out_ready),
        .out_sample(out_sample), .out_channel(out_channel), .slow(slow), .clr(clr),
        .n_acc(n_acc), .n_nz(n_nz), .n_cross(n_cross), .sum(sum), .last_ch(last_ch));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
        tick();
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
        reg_addr = a;
        tick();
        tick();
        d = reg_rdata;
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (20) tick();
        nrst = 1'b1;
    endtask

    task automatic pulse_clr();
        clr = 1'b1;
        tick();
        clr = 1'b0;
    endtask

    task automatic wait_acc(input int k);
        int lim;
        lim = k + n_acc;
        for (int i = 0; i < k * 80 && n_acc < lim; i++) tick();
    endtask

    task automatic wait_go_clear();
        logic [7:0] d;
        d = 8'hff;
        for (int i = 0; i < 12000 && d[CTL_GO]; i++) reg_read(REG_CONTROL, d);
        check(32'(d[CTL_GO]), 32'h0);
    endtask

    task automatic t_regs();
        logic [4:0] adr [5];
        logic [7:0] d;
        adr = '{REG_FLAG_LEN, REG_MSG_COUNT, REG_SEIZE_LEN, REG_MARK_LEN, REG_CONTROL};
        foreach (adr[i]) begin
            reg_read(adr[i], d);
            check(32'(d), 32'(REG_RESET));
        end
        for (int i = 0; i < 4; i++) begin
            reg_write(adr[i], 8'hc0 + 8'(i));
            reg_read(adr[i], d);
            check(32'(d), 32'(8'hc0 + 8'(i)));
        end
        reg_write(REG_CONTROL, 8'hea);
        reg_read(REG_CONTROL, d);
        check(32'(d), 32'h2a);
        reg_write(REG_CONTROL, 8'h10);
        reg_read(REG_CONTROL, d);
        check(32'(d), 32'h0);
        reg_read(5'h00, d);
        check(32'(d), 32'h0);
    endtask

    task automatic t_buffer();
        for (int i = 0; i < BUF_DEPTH; i++) begin
            tick();
            buf_wr = 1'b1;
            buf_addr = BUF_AW'(i);
            buf_wdata = 8'(i * 37) ^ 8'h80;
            tick();
            buf_wr = 1'b0;
        end
        for (int i = BUF_DEPTH - 1; i >= 0; i--) begin
            buf_addr = BUF_AW'(i);
            tick();
            tick();
            check(32'(buf_rdata), 32'(8'(i * 37) ^ 8'h80));
        end
    endtask

    task automatic t_idle();
        pulse_clr();
        repeat (400) tick();
        check(32'(n_nz), 32'h0);
    endtask

    // whole frame; the same frame is later taken by a stalling receiver
    task automatic run_frame(input logic s, output logic [31:0] cs, output int nz);
        int bits;
        int exp;
        do_reset();
        slow = 1'b0;
        reg_write(REG_SEIZE_LEN, 8'h01);
        reg_write(REG_MARK_LEN, 8'h03);
        reg_write(REG_FLAG_LEN, 8'h02);
        reg_write(REG_MSG_COUNT, 8'h02);
        pulse_clr();
        reg_write(REG_CONTROL, 8'h15);
        // stall only after the start, so both runs enter the frame at one tone phase
        slow = s;
        wait_go_clear();
        // words still buffered when go drops
        wait_acc(4);
        bits = 4 * 1 + 3 + 2 * (10 + 2);
        exp = bits * SAMPLE_HZ / BAUD;
        nz = n_nz;
        check(32'(nz >= exp - 8 && nz <= exp + 3), 32'h1);
        wait_acc(20);
        check(32'(n_nz), 32'(nz));
        check(32'(last_ch), 32'h2);
        cs = sum;
    endtask

    task automatic t_frames();
        run_frame(1'b0, cs_a, nz_a);
        run_frame(1'b1, cs_b, nz_b);
        check(cs_b, cs_a);
        check(32'(nz_b), 32'(nz_a));
    endtask

    task automatic run_hold(input logic std, input int hz);
        int exp;
        do_reset();
        slow = 1'b0;
        reg_write(REG_SEIZE_LEN, 8'h02);
        reg_write(REG_MARK_LEN, 8'h00);
        reg_write(REG_FLAG_LEN, 8'h00);
        reg_write(REG_MSG_COUNT, 8'h01);
        reg_write(REG_CONTROL, 8'h31 | {4'h0, std, 3'h0});
        wait_go_clear();
        pulse_clr();
        wait_acc(400);
        exp = 2 * hz * 400 / SAMPLE_HZ;
        check(32'(n_cross >= exp - 4 && n_cross <= exp + 4), 32'h1);
        reg_write(REG_CONTROL, 8'h01 | {4'h0, std, 3'h0});
        reg_write(REG_CONTROL, 8'h21 | {4'h0, std, 3'h0});
        pulse_clr();
        wait_acc(40);
        check(32'(n_nz), 32'h0);
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        do_reset();
        t_regs();
        t_buffer();
        t_idle();
        t_frames();
        run_hold(1'b0, BELL_MARK_HZ);
        run_hold(1'b1, V23_MARK_HZ);
        give_verdict();
    end
endmodule
`default_nettype wire
